// ---- src/tpc_pkg.sv ----
/*
  Shared constants and types of the timer/PWM core: register offsets,
  field positions, clock source and channel mode codes, bus responses.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package tpc_pkg;

	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_SC      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CNT     = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MOD     = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PIN     = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CH_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] CH_STRIDE   = 8'h08;
	localparam logic [ADDR_W-1:0] CH_VAL_OFF  = 8'h04;

	// status/control field positions
	localparam int SC_TOF  = 7;
	localparam int CH_FLAG = 7;

	// clock source select codes
	localparam logic [1:0] CLK_OFF = 2'h0;
	localparam logic [1:0] CLK_BUS = 2'h1;
	localparam logic [1:0] CLK_FIX = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;

	// channel mode and edge/level codes
	localparam logic [1:0] MODE_CAP = 2'h0;
	localparam logic [1:0] MODE_CMP = 2'h1;
	localparam logic [1:0] ELS_NONE = 2'h0;
	localparam logic [1:0] ELS_TGL  = 2'h1;
	localparam logic [1:0] ELS_CLR  = 2'h2;
	localparam logic [1:0] ELS_SET  = 2'h3;

	// counter values
	localparam int         PRE_W    = 7;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONES = 16'hFFFF;
	localparam logic [15:0] CNT_ONE  = 16'h0001;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       overflow_flag;
		logic       toie;
		logic       center_aligned_pwm;
		logic [1:0] clks;
		logic [2:0] ps;
	} tpc_sc_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] els;
	} tpc_chcfg_t;

	typedef struct packed {
		logic       flag;
		logic       ie;
		tpc_chcfg_t cfg;
		logic [1:0] rsvd;
	} tpc_chsc_t;

endpackage

// ---- src/tpc_channel.sv ----
/*
  One timer channel: input capture, output compare, buffered PWM.
  Assumes the counter, its advance pulse and its reload pulse come from
  the core on the same clock; the pin input is asynchronous.
*/
`timescale 1ns/1ns
module tpc_channel (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               srst,
	// configuration
	input  wire tpc_pkg::tpc_chcfg_t cfg,
	input  wire logic               center_aligned_pwm,
	input  wire logic               pin_block,
	// time base
	input  wire logic [15:0]        cnt,
	input  wire logic               step,
	input  wire logic               ovf,
	// value write
	input  wire logic               wr_val,
	input  wire logic [15:0]        wdata,
	// results
	output logic                    event_p,
	output logic [15:0]             val_q,
	// pin side
	input  wire logic               pin_in,
	output logic                    pin_out,
	output logic                    pin_oe,
	output logic                    pin_own
);
	import tpc_pkg::*;

	logic        in_m_q;
	logic        in_s_q;
	logic        in_p_q;
	logic [15:0] act_q;
	logic        out_q;
	logic        is_cap;
	logic        is_cmp;
	logic        is_pwm;
	logic        rise;
	logic        fall;
	logic        cap_hit;
	logic        match;
	logic        level;

	assign is_cap  = !center_aligned_pwm && cfg.mode == MODE_CAP;
	assign is_cmp  = !center_aligned_pwm && cfg.mode == MODE_CMP;
	assign is_pwm  = !is_cap && !is_cmp;
	assign rise    = in_s_q & ~in_p_q;
	assign fall    = ~in_s_q & in_p_q;
	// R16 edge choice
	assign cap_hit = is_cap && !pin_block && ((cfg.els[0] && rise) || (cfg.els[1] && fall));
	assign match   = step && cnt == act_q;
	assign event_p = cap_hit || (!is_cap && match);
	// R09 R12 pin ownership
	assign pin_own = !pin_block && cfg.els != ELS_NONE;
	assign pin_oe  = pin_own && !is_cap;
	assign pin_out = out_q;
	assign level   = cnt < act_q;

	// R07 two-flop input sync
	always_ff @(posedge sys_clk) begin
		in_m_q <= pin_in;
		in_s_q <= in_m_q;
		in_p_q <= in_s_q;
	end

	// R15 capture or buffered value
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			val_q <= CNT_ZERO;
			act_q <= CNT_ZERO;
		end else begin
			if (cap_hit)
				val_q <= cnt;
			else if (wr_val)
				val_q <= wdata;
			// pwm duty only takes effect at the reload point
			if (!is_pwm || ovf)
				act_q <= val_q;
		end
	end

	// R17 R18 output action
	always_ff @(posedge sys_clk) begin
		if (srst)
			out_q <= 1'b0;
		else if (is_pwm)
			out_q <= cfg.els[0] ? ~level : level;
		else if (is_cmp && match) begin
			case (cfg.els)
				ELS_TGL: out_q <= ~out_q;
				ELS_CLR: out_q <= 1'b0;
				ELS_SET: out_q <= 1'b1;
				default: out_q <= out_q;
			endcase
		end
	end

endmodule

// ---- src/tpc_core.sv ----
/*
  Timer/PWM core: 16-bit counter with clock select, prescaler and modulo,
  NCH channels, AXI4-Lite register slave and pin steering against GPIO.
  Assumes pins and the oscillator reference are asynchronous, and that
  the clock generator drives its FLL mode level on the bus clock.
*/
// Added by the designer: the register offsets and the AXI4-Lite register port.
// How it works
// R01: 16-bit counter free-runs, counts to modulo, or counts up/down.
// R02: modulo of all zeros or all ones gives full 16-bit range.
// R03: counter reads never disturb the counting sequence.
// R04: any write to the counter register clears the counter.
// R05: prescaler divides the selected source by 1 to 128.
// R06: clock select code three drives prescaler from the external pin.
// R07: external clock passes a two-flop bus clock synchroniser.
// R08: external clock source stays at or below a quarter bus rate.
// R09: a channel sharing the clock pin leaves the pin alone.
// R10: software sets that channel's edge/level bits to zero.
// R11: timer-owned pins ignore GPIO data and direction.
// R12: channels needing no pin hand it back to GPIO.
// R13: after reset timer off, pins GPIO inputs, pullups off.
// R14: timer input pins have a software-enabled passive pullup.
// R15: each channel is capture, compare or buffered edge PWM.
// R16: capture triggers on rising, falling or either edge.
// R17: compare match sets, clears or toggles the output.
// R18: PWM output polarity is chosen per channel.
// R19: one control bit turns all channels to center-aligned PWM.
// R20: one interrupt request per channel plus one for overflow.
// R21: fixed clock is oscillator half rate only in FLL external mode.
// R22: channel count is a parameter, six or two.
// R23: clock select zero stops, one bus clock, two fixed clock.
// R24: overflow flag sets when counter wraps from modulo to zero; in center-aligned mode it sets at modulo, as the count turns down.
// R25: three-bit prescale field doubles the divisor per step.
// R26: counter steps once per prescaler pulse, holds with no source.
`timescale 1ns/1ns
module tpc_core #(
	parameter int NCH    = 6,
	parameter int EXT_CH = 0
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	// axi4-lite write
	input  wire logic [tpc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// axi4-lite read
	input  wire logic [tpc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// clock sources
	input  wire logic                      ext_timer_clk_pin,
	input  wire logic                      osc_ref_clk_pin,
	input  wire logic                      fll_ext_ref_mode,
	// channel pins
	input  wire logic [NCH-1:0]            ch_pin_in,
	output logic [NCH-1:0]                 ch_pin_out,
	output logic [NCH-1:0]                 ch_pin_oe,
	output logic [NCH-1:0]                 ch_pullup_en,
	// gpio port controls
	input  wire logic [NCH-1:0]            gpio_out,
	input  wire logic [NCH-1:0]            gpio_oe,
	// interrupt requests
	output logic [NCH-1:0]                 ch_irq,
	output logic                           tof_irq
);
	import tpc_pkg::*;

	// bus side
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [1:0]          rresp_q;
	logic [31:0]         rdata_q;
	logic                wr_fire;
	logic                rd_fire;
	logic                wr_sc;
	logic                wr_cnt;
	logic                wr_mod;
	logic                wr_pin;
	logic                wr_ok;
	logic                rd_sc;
	logic                rd_ok;
	logic [31:0]         rd_word;

	// timer state
	tpc_sc_t             sc_q;
	logic [15:0]         mod_q;
	logic [15:0]         cnt_q;
	logic [15:0]         cnt_d;
	logic                down_q;
	logic                down_d;
	logic                wrap_c;
	logic [PRE_W-1:0]    pre_q;
	logic [PRE_W-1:0]    ps_mask;
	logic                step_q;
	logic                ovf_q;
	logic                tof_arm_q;
	logic                tof_set;
	logic                tof_clr;
	logic [NCH-1:0]      pu_q;

	// clock sources
	logic                ext_m_q;
	logic                ext_s_q;
	logic                ext_p_q;
	logic                osc_m_q;
	logic                osc_s_q;
	logic                osc_p_q;
	logic                osc_half_q;
	logic                ext_tick;
	logic                fix_tick;
	logic                src_tick;
	logic                adv;
	logic [15:0]         mod_eff;
	logic                at_top;

	// channel side
	tpc_chsc_t           chsc_q [NCH];
	logic                ch_arm_q [NCH];
	logic [ADDR_W-1:0]   ch_sc_addr [NCH];
	logic [ADDR_W-1:0]   ch_val_addr [NCH];
	logic [15:0]         ch_val [NCH];
	logic [NCH-1:0]      ch_event;
	logic [NCH-1:0]      wr_ch_sc;
	logic [NCH-1:0]      wr_ch_val;
	logic [NCH-1:0]      tmr_out;
	logic [NCH-1:0]      tmr_oe;
	logic [NCH-1:0]      tmr_own;

	// write and read handshakes, address and data taken together
	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rd_fire       = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	assign wr_sc  = wr_fire && s_axi_awaddr == OFF_SC && s_axi_wstrb[0];
	// R04 any lane clears
	assign wr_cnt = wr_fire && s_axi_awaddr == OFF_CNT;
	assign wr_mod = wr_fire && s_axi_awaddr == OFF_MOD;
	assign wr_pin = wr_fire && s_axi_awaddr == OFF_PIN;
	assign wr_ok  = s_axi_awaddr == OFF_SC || s_axi_awaddr == OFF_CNT
		|| s_axi_awaddr == OFF_MOD || s_axi_awaddr == OFF_PIN
		|| (|wr_ch_sc) || (|wr_ch_val);
	assign rd_sc  = s_axi_araddr == OFF_SC;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// R03 reads are side-effect free on the counter
	always_comb begin
		rd_word = '0;
		rd_ok   = 1'b1;
		if (rd_sc)
			rd_word[7:0] = sc_q;
		else if (s_axi_araddr == OFF_CNT)
			rd_word[15:0] = cnt_q;
		else if (s_axi_araddr == OFF_MOD)
			rd_word[15:0] = mod_q;
		else if (s_axi_araddr == OFF_PIN)
			rd_word[NCH-1:0] = pu_q;
		else begin
			rd_ok = 1'b0;
			for (int k = 0; k < NCH; k++) begin
				if (s_axi_araddr == ch_sc_addr[k]) begin
					rd_word[7:0] = {chsc_q[k].flag, chsc_q[k].ie, chsc_q[k].cfg, 2'h0};
					rd_ok        = 1'b1;
				end
				if (s_axi_araddr == ch_val_addr[k]) begin
					rd_word[15:0] = ch_val[k];
					rd_ok         = 1'b1;
				end
			end
		end
	end

	// R07 two-flop synchronisers
	always_ff @(posedge sys_clk) begin
		ext_m_q <= ext_timer_clk_pin;
		ext_s_q <= ext_m_q;
		ext_p_q <= ext_s_q;
		osc_m_q <= osc_ref_clk_pin;
		osc_s_q <= osc_m_q;
		osc_p_q <= osc_s_q;
	end

	// R21 half rate from every other reference edge
	always_ff @(posedge sys_clk) begin
		if (srst)
			osc_half_q <= 1'b0;
		else if (osc_s_q && !osc_p_q)
			osc_half_q <= ~osc_half_q;
	end

	assign ext_tick = ext_s_q && !ext_p_q;
	// R21 otherwise equal to bus rate
	assign fix_tick = fll_ext_ref_mode ? (osc_s_q && !osc_p_q && osc_half_q) : 1'b1;

	// R06 R23 source select
	assign src_tick = (sc_q.clks == CLK_BUS)
		|| (sc_q.clks == CLK_FIX && fix_tick)
		|| (sc_q.clks == CLK_EXT && ext_tick);

	// R25 mask doubles per step
	assign ps_mask = ~({PRE_W{1'b1}} << sc_q.ps);
	// R05 prescaler terminal
	assign adv     = src_tick && (pre_q & ps_mask) == ps_mask;

	always_ff @(posedge sys_clk) begin
		if (srst || wr_cnt)
			pre_q <= '0;
		else if (src_tick)
			pre_q <= pre_q + 1'b1;
	end

	// R02 zero or ones run full range
	assign mod_eff = (mod_q == CNT_ZERO || mod_q == CNT_ONES) ? CNT_ONES : mod_q;
	assign at_top  = cnt_q == mod_eff;

	// R01 R19 up or up/down sequence
	always_comb begin
		cnt_d  = cnt_q + CNT_ONE;
		down_d = down_q;
		wrap_c = 1'b0;
		if (!sc_q.center_aligned_pwm) begin
			down_d = 1'b0;
			if (at_top) begin
				cnt_d  = CNT_ZERO;
				wrap_c = 1'b1;
			end
		end else if (!down_q) begin
			if (at_top) begin
				down_d = 1'b1;
				cnt_d  = mod_eff - CNT_ONE;
				wrap_c = 1'b1;
			end
		end else if (cnt_q == CNT_ZERO) begin
			down_d = 1'b0;
		end else begin
			cnt_d = cnt_q - CNT_ONE;
		end
	end

	// R24 wrap sets overflow
	assign tof_set = adv && wrap_c;
	// flag cleared by reading it set, then writing zero
	assign tof_clr = wr_sc && !s_axi_wdata[SC_TOF] && tof_arm_q;

	// R26 one count per prescaler pulse
	always_ff @(posedge sys_clk) begin
		if (srst || wr_cnt) begin
			cnt_q  <= CNT_ZERO;
			down_q <= 1'b0;
		end else if (adv) begin
			cnt_q  <= cnt_d;
			down_q <= down_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			step_q <= 1'b0;
			ovf_q  <= 1'b0;
		end else begin
			step_q <= adv;
			ovf_q  <= tof_set;
		end
	end

	// R13 reset leaves timer off
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sc_q  <= '0;
			mod_q <= CNT_ZERO;
			pu_q  <= '0;
		end else begin
			if (wr_sc)
				sc_q <= {tof_set || (sc_q.overflow_flag && !tof_clr), s_axi_wdata[6:0]};
			else
				sc_q.overflow_flag <= tof_set || sc_q.overflow_flag;
			if (wr_mod && s_axi_wstrb[0])
				mod_q[7:0] <= s_axi_wdata[7:0];
			if (wr_mod && s_axi_wstrb[1])
				mod_q[15:8] <= s_axi_wdata[15:8];
			if (wr_pin && s_axi_wstrb[0])
				pu_q <= s_axi_wdata[NCH-1:0];
		end
	end

	// a new overflow restarts the clear sequence
	always_ff @(posedge sys_clk) begin
		if (srst || tof_set || wr_sc)
			tof_arm_q <= 1'b0;
		else if (rd_fire && rd_sc && sc_q.overflow_flag)
			tof_arm_q <= 1'b1;
	end

	// R20 overflow request
	assign tof_irq = sc_q.overflow_flag && sc_q.toie;

	// R22 one slice per channel
	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			logic        blk;
			logic        clr;
			logic [15:0] wval;

			assign ch_sc_addr[i]  = OFF_CH_BASE + ADDR_W'(i) * CH_STRIDE;
			assign ch_val_addr[i] = ch_sc_addr[i] + CH_VAL_OFF;
			assign wr_ch_sc[i]    = wr_fire && s_axi_awaddr == ch_sc_addr[i] && s_axi_wstrb[0];
			assign wr_ch_val[i]   = wr_fire && s_axi_awaddr == ch_val_addr[i];
			assign clr            = wr_ch_sc[i] && !s_axi_wdata[CH_FLAG] && ch_arm_q[i];
			assign wval[7:0]      = s_axi_wstrb[0] ? s_axi_wdata[7:0] : ch_val[i][7:0];
			assign wval[15:8]     = s_axi_wstrb[1] ? s_axi_wdata[15:8] : ch_val[i][15:8];
			// R09 shared clock pin released
			assign blk = (i == EXT_CH) && sc_q.clks == CLK_EXT;

			// event wins over a clear in the same cycle
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					chsc_q[i] <= '0;
				end else begin
					if (wr_ch_sc[i]) begin
						chsc_q[i].ie  <= s_axi_wdata[6];
						chsc_q[i].cfg <= s_axi_wdata[5:2];
					end
					chsc_q[i].flag <= ch_event[i] || (chsc_q[i].flag && !clr);
				end
			end

			always_ff @(posedge sys_clk) begin
				if (srst || ch_event[i] || wr_ch_sc[i])
					ch_arm_q[i] <= 1'b0;
				else if (rd_fire && s_axi_araddr == ch_sc_addr[i] && chsc_q[i].flag)
					ch_arm_q[i] <= 1'b1;
			end

			tpc_channel u_ch (
				.sys_clk   (sys_clk),
				.srst      (srst),
				.cfg       (chsc_q[i].cfg),
				.center_aligned_pwm      (sc_q.center_aligned_pwm),
				.pin_block (blk),
				.cnt       (cnt_q),
				.step      (step_q),
				.ovf       (ovf_q),
				.wr_val    (wr_ch_val[i]),
				.wdata     (wval),
				.event_p   (ch_event[i]),
				.val_q     (ch_val[i]),
				.pin_in    (ch_pin_in[i]),
				.pin_out   (tmr_out[i]),
				.pin_oe    (tmr_oe[i]),
				.pin_own   (tmr_own[i])
			);

			// R11 R12 pin steering
			assign ch_pin_out[i]   = tmr_own[i] ? tmr_out[i] : gpio_out[i];
			assign ch_pin_oe[i]    = tmr_own[i] ? tmr_oe[i] : gpio_oe[i];
			// R14 pullup on timer inputs
			assign ch_pullup_en[i] = pu_q[i] && tmr_own[i] && !tmr_oe[i];
			// R20 channel request
			assign ch_irq[i]       = chsc_q[i].flag && chsc_q[i].ie;
		end
	endgenerate

endmodule

// ---- bench/tpc_core_props.sv ----
/*
  Checker for the timer core: register bus handshake and pin steering.
  Sees only the core ports; attached by the bind at the foot.
*/
`timescale 1ns/1ns
module tpc_core_props #(
	parameter int NCH = 6
) (
	// clock and reset
	input wire logic                       sys_clk,
	input wire logic                       srst,
	// register bus
	input wire logic [tpc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic [3:0]                 s_axi_wstrb,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [tpc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	// pins and requests
	input wire logic [NCH-1:0]             ch_pin_out,
	input wire logic [NCH-1:0]             ch_pin_oe,
	input wire logic [NCH-1:0]             ch_pullup_en,
	input wire logic [NCH-1:0]             gpio_out,
	input wire logic [NCH-1:0]             gpio_oe,
	input wire logic [NCH-1:0]             ch_irq,
	input wire logic                       tof_irq
);
	import tpc_pkg::*;
	localparam int TOP = int'(OFF_CH_BASE) + int'(CH_STRIDE) * NCH;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire wr_go   = s_axi_awvalid & s_axi_wvalid & !s_axi_bvalid;
	wire rd_go   = s_axi_arvalid & s_axi_arready;
	wire wr_good = s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr < TOP;
	wire rd_bad  = s_axi_araddr[1:0] != 2'h0 || s_axi_araddr >= TOP;

	a_wr_answer: assert property (wr_go |=> s_axi_bvalid)
		else $error("write answer late");
	a_rd_answer: assert property (rd_go |=> s_axi_rvalid)
		else $error("read answer late");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rd_refused: assert property (rd_go && rd_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("bad read not refused");
	a_wr_okay: assert property (wr_go && wr_good && s_axi_wstrb == 4'hF |=> s_axi_bresp == RESP_OKAY)
		else $error("good write refused");
	a_reset_pins: assert property ($fell(srst) |-> ch_pin_out == gpio_out && ch_pin_oe == gpio_oe
		&& ch_pullup_en == '0 && ch_irq == '0 && !tof_irq)
		else $error("pins not released after reset");
	a_pullup_input: assert property ((ch_pullup_en & ch_pin_oe) == '0)
		else $error("pullup on a driven pin");
endmodule

bind tpc_core tpc_core_props #(.NCH(NCH)) tpc_core_props_i (.sys_clk, .srst, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch_pin_out, .ch_pin_oe, .ch_pullup_en,
	.gpio_out, .gpio_oe, .ch_irq, .tof_irq);

// ---- bench/tpc_pin_model.sv ----
/*
  Far side of the timer pins: external clock source, reference, inputs.
  Assumes ext_run is high only for counted runs.
*/
`timescale 1ns/1ns
module tpc_pin_model #(
	parameter int NCH = 6
) (
	// clock
	input wire logic           sys_clk,
	// bench controls
	input wire logic           ext_run,
	input wire logic [NCH-1:0] drv_en,
	input wire logic [NCH-1:0] drv_val,
	// core pins
	input wire logic [NCH-1:0] ch_pin_out,
	input wire logic [NCH-1:0] ch_pin_oe,
	input wire logic [NCH-1:0] ch_pullup_en,
	output logic               ext_timer_clk_pin,
	output logic               osc_ref_clk_pin,
	output logic [NCH-1:0]     ch_pin_in
);
	logic [2:0]     div_q = 3'h0;
	logic [1:0]     ref_q = 2'h0;
	logic [NCH-1:0] float_q = '0;
	always @(posedge sys_clk) begin
		div_q <= ext_run ? div_q + 3'h1 : 3'h0;
		ref_q <= ref_q + 2'h1;
		float_q <= ~float_q;
	end
	// eighth of bus rate, still outside runs
	assign ext_timer_clk_pin = div_q[2];
	assign osc_ref_clk_pin = ref_q[1];
	// undriven pins wander unless pulled up
	assign ch_pin_in = ch_pin_oe & ch_pin_out
		| ~ch_pin_oe & (drv_en & drv_val | ~drv_en & (ch_pullup_en | float_q));
endmodule

// ---- bench/tb_tpc_core.sv ----
/*
  Self-checking bench for the timer core over its register bus.
  Assumes the pin model on the far side and the bound checker.
*/
`timescale 1ns/1ns
module tb_tpc_core;
	import tpc_pkg::*;
	localparam int NCH = 6;
	localparam logic [7:0] CH1 = OFF_CH_BASE + CH_STRIDE;
	localparam logic [7:0] CH2 = CH1 + CH_STRIDE;
	logic              sys_clk = 1'b0;
	logic              srst = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rv, rv2;
	logic [3:0]        s_axi_wstrb = '0;
	logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic              s_axi_arvalid = 0, s_axi_rready = 0, ext_run = 0, fll = 0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              ext_timer_clk_pin, osc_ref_clk_pin, tof_irq;
	logic [NCH-1:0]    drv_en = 6'h04, drv_val = '0, gpio_out = 6'h2A, gpio_oe = 6'h15;
	logic [NCH-1:0]    ch_pin_in, ch_pin_out, ch_pin_oe, ch_pullup_en, ch_irq;
	logic [1:0]        acts [4] = '{ELS_SET, ELS_CLR, ELS_TGL, ELS_TGL};
	int                error_cnt = 0, compares = 0, cyc = 0, t0;

	tpc_core #(.NCH(NCH), .EXT_CH(0)) tpc_core_i (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_timer_clk_pin, .osc_ref_clk_pin,
		.fll_ext_ref_mode(fll), .ch_pin_in, .ch_pin_out, .ch_pin_oe, .ch_pullup_en, .gpio_out,
		.gpio_oe, .ch_irq, .tof_irq);
	tpc_pin_model #(.NCH(NCH)) tpc_pin_model_i (.sys_clk, .ext_run, .drv_en, .drv_val,
		.ch_pin_out, .ch_pin_oe, .ch_pullup_en, .ext_timer_clk_pin, .osc_ref_clk_pin, .ch_pin_in);

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic final_report;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
		compares++;
		if ((tol == 0 ? g === e : g - e <= tol) !== 1'b1) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
		input logic [1:0] r = RESP_OKAY);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, r}, 0);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk({30'h0, s_axi_rresp}, {30'h0, r}, 0);
	endtask

	// hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			final_report();
		end
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		rd(OFF_SC, rv);
		chk(rv, 32'h0, 0);
		chk({26'h0, ch_pullup_en}, 32'h0, 0);
		rd(8'hF0, rv, RESP_SLVERR);
		chk(rv, 32'h0, 0);
		wr(8'h02, 32'h1, 4'hF, RESP_SLVERR);
		// polled reads
		for (int p = 0; p < 8; p++) begin
			wr(OFF_CNT, 32'hA5A5, 4'h1 << (p % 5));
			rd(OFF_CNT, rv);
			chk(rv, 32'h0, 0);
			fll <= &p[1:0];
			wr(OFF_SC, {27'h0, p[0] ? CLK_FIX : CLK_BUS, p[2:0]});
			t0 = cyc;
			while (cyc - t0 < 1024) rd(OFF_CNT, rv2);
			wr(OFF_SC, 32'h0);
			rd(OFF_CNT, rv);
			chk(rv, 32'd1024 >> p >> 3 * fll, 8);
			repeat (20) @(posedge sys_clk);
			rd(OFF_CNT, rv2);
			chk(rv2, rv, 0);
		end
		wr(OFF_MOD, 32'h4);
		wr(OFF_CNT, 32'h0);
		wr(OFF_SC, 32'h48);
		repeat (20) @(posedge sys_clk);
		rd(OFF_CNT, rv);
		chk(rv, 32'h0, 4);
		rd(OFF_SC, rv);
		chk(rv, 32'hC8, 0);
		chk({31'h0, tof_irq}, 32'h1, 0);
		wr(OFF_SC, 32'h40);
		rd(OFF_SC, rv);
		wr(OFF_SC, 32'h40);
		chk({31'h0, tof_irq}, 32'h0, 0);
		wr(OFF_SC, 32'h68);
		repeat (30) @(posedge sys_clk);
		rd(OFF_SC, rv);
		chk(rv, 32'hE8, 0);
		wr(OFF_SC, 32'h0);
		wr(OFF_MOD, 32'h0);
		wr(OFF_CNT, 32'h0);
		wr(OFF_SC, 32'h08);
		repeat (40) @(posedge sys_clk);
		wr(OFF_SC, 32'h0);
		rd(OFF_CNT, rv);
		chk(rv, 32'd40, 6);
		wr(OFF_CH_BASE + CH_VAL_OFF, 32'h10);
		wr(OFF_CH_BASE, {24'h0, 2'b00, MODE_CMP, ELS_NONE, 2'h0});
		wr(OFF_CNT, 32'h0);
		ext_run <= 1'b1;
		wr(OFF_SC, {27'h0, CLK_EXT, 3'h0});
		wr(OFF_CH_BASE, 32'h0C);
		chk({31'h0, ch_pin_oe[0]}, {31'h0, gpio_oe[0]}, 0);
		wr(OFF_CH_BASE, 32'h10);
		repeat (512) @(posedge sys_clk);
		wr(OFF_SC, 32'h0);
		ext_run <= 1'b0;
		rd(OFF_CNT, rv);
		chk(rv, 32'd62, 4);
		rd(OFF_CH_BASE, rv);
		chk(rv, 32'h90, 0);
		wr(CH1 + CH_VAL_OFF, 32'h8);
		for (int i = 0; i < 4; i++) begin
			wr(CH1, {24'h0, 2'b01, MODE_CMP, acts[i], 2'h0});
			wr(OFF_CNT, 32'h0);
			wr(OFF_SC, 32'h08);
			repeat (16) @(posedge sys_clk);
			wr(OFF_SC, 32'h0);
			chk({31'h0, ch_pin_oe[1]}, 32'h1, 0);
			chk({31'h0, ch_pin_out[1]}, {31'h0, ~i[0]}, 0);
			chk({31'h0, ch_irq[1]}, 32'h1, 0);
			rd(CH1, rv);
			wr(CH1, {24'h0, 2'b01, MODE_CMP, acts[i], 2'h0});
			chk({31'h0, ch_irq[1]}, 32'h0, 0);
		end
		wr(CH1, 32'h24);
		wr(OFF_PIN, 32'h4);
		chk({31'h0, ch_pin_out[1]}, 32'h1, 0);
		wr(CH1, 32'h0);
		chk({26'h0, ch_pin_oe}, {26'h0, gpio_oe}, 0);
		chk({26'h0, ch_pin_out}, {26'h0, gpio_out}, 0);
		for (int e = 1; e < 4; e++) begin
			wr(CH2, {26'h0, e[1:0], 2'h0});
			chk({31'h0, ch_pullup_en[2]}, 32'h1, 0);
			drv_val[2] <= 1'b1;
			repeat (8) @(posedge sys_clk);
			rd(CH2, rv);
			chk({31'h0, rv[7]}, {31'h0, e != 2}, 0);
			wr(CH2, {26'h0, e[1:0], 2'h0});
			drv_val[2] <= 1'b0;
			repeat (8) @(posedge sys_clk);
			rd(CH2, rv);
			chk({31'h0, rv[7]}, {31'h0, e != 1}, 0);
			wr(CH2, {26'h0, e[1:0], 2'h0});
		end
		final_report();
	end
endmodule
